// ---- verilog/qspf_pins.sv ----
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Select fall starts a new transaction
// - Select rise closes the current transaction
// - Select low means active, lanes respond
// - Select high gives standby unless busy
// - Deselected: inputs ignored, outputs released
// - Reset pin works while deselected too
// - SDR: sample on rise, launch on fall
// - DDR: sample and drive both edges
// - Lane zero input, or data lane
// - Lane one output, or data lane
// - Lane two write protect, quad data
// - Lane three reset when idle or non-quad
// - Reset low reinitialises to standby
// - Reset low releases all four lanes
// - Reset pin idles high by pull-up
module qspf_pins (
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    input wire logic I_CS_N,
    input wire logic I_SCK,
    input wire logic [3:0] I_LANE,
    input wire logic I_HW_RESET_N,
    input wire logic I_HW_RESET_PRESENT,
    input wire qspf_pkg::qspf_cfg_s I_CFG,
    input wire logic I_EMBEDDED_BUSY,
    input wire logic [7:0] I_TX_BYTE,
    output logic [3:0] O_LANE,
    output logic [3:0] O_LANE_OE,
    output logic O_START,
    output logic O_END,
    output logic O_ACTIVE,
    output logic O_STANDBY,
    output logic O_WP_N,
    output logic O_RESET_REQ,
    output logic [7:0] O_RX_BYTE,
    output logic O_RX_VALID,
    output logic O_TX_TAKE
);
    logic [6:0] sync_q;
    logic cs_n_s, sck_s, hw_pin_s;
    logic [3:0] lane_s;
    logic cs_d_r, sck_d_r;
    qspf_pkg::qspf_state_e state_r, state_nxt;
    logic [7:0] rx_sh_r, tx_sh_r;
    logic [3:0] bits_r;
    qspf_pkg::qspf_lanes_s drv_r;

    // Unconnected pins float high; sync preset to 1 matches pull-up
    qspf_sync #(.W(7)) u_sync (
        .i_clk(I_CLK_SYS),
        .i_rst_n(I_RST_N),
        .i_d({I_CS_N, I_SCK, I_HW_RESET_N, I_LANE}),
        .o_q(sync_q)
    );
    assign {cs_n_s, sck_s, hw_pin_s, lane_s} = sync_q;
    // Strap gated after the sync, so no logic sits ahead of the first flop
    wire hw_rst_s = hw_pin_s | ~I_HW_RESET_PRESENT;

    wire quad = I_CFG.width == qspf_pkg::WIDTH_X4;
    wire dual = I_CFG.width == qspf_pkg::WIDTH_X2;
    wire sel = !cs_n_s;
    wire cs_fall = cs_d_r && !cs_n_s;
    wire cs_rise = !cs_d_r && cs_n_s;
    wire sck_rise = !sck_d_r && sck_s;
    wire sck_fall = sck_d_r && !sck_s;
    // Lane three as reset only outside quad frames
    wire l3_rst = I_CFG.reset_on_lane3 && (cs_n_s || !quad) && !lane_s[3];
    wire rst_any = !hw_rst_s || l3_rst;
    wire samp = sel && !rst_any && (sck_rise || (I_CFG.ddr && sck_fall));
    wire launch = sel && !rst_any && (sck_fall || (I_CFG.ddr && sck_rise));
    wire [3:0] step = quad ? 4'h4 : (dual ? 4'h2 : 4'h1);
    wire [7:0] rx_in = quad ? {rx_sh_r[3:0], lane_s} :
                       dual ? {rx_sh_r[5:0], lane_s[1:0]} : {rx_sh_r[6:0], lane_s[0]};
    wire [3:0] bits_n = bits_r + step;
    wire byte_done = bits_n >= 4'(qspf_pkg::SHIFT_BITS);
    // Counter is shared with receive: a byte loads at a bit-count boundary
    wire tx_load = cs_fall || (launch && bits_r == 4'h0);
    wire [7:0] tx_src = tx_load ? I_TX_BYTE : tx_sh_r;
    wire [3:0] tx_val = quad ? tx_src[7:4] : dual ? {2'h0, tx_src[7:6]} : {2'h0, tx_src[7], 1'b0};
    wire [3:0] tx_oe = quad ? 4'hf : dual ? 4'h3 : 4'h2;
    wire [7:0] tx_next = quad ? {tx_src[3:0], 4'h0} :
                         dual ? {tx_src[5:0], 2'h0} : {tx_src[6:0], 1'b0};

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            qspf_pkg::ST_STANDBY: if (cs_fall) state_nxt = qspf_pkg::ST_ACTIVE;
            qspf_pkg::ST_ACTIVE: begin
                if (cs_rise) state_nxt = I_EMBEDDED_BUSY ? qspf_pkg::ST_BUSY : qspf_pkg::ST_STANDBY;
            end
            qspf_pkg::ST_BUSY: begin
                if (cs_fall) state_nxt = qspf_pkg::ST_ACTIVE;
                else if (!I_EMBEDDED_BUSY) state_nxt = qspf_pkg::ST_STANDBY;
            end
            default: state_nxt = qspf_pkg::ST_STANDBY;
        endcase
        if (rst_any) state_nxt = qspf_pkg::ST_STANDBY;
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cs_d_r <= 1'b1;
            // Same as the sync preset: no false clock edge out of reset
            sck_d_r <= 1'b1;
            state_r <= qspf_pkg::ST_STANDBY;
        end else begin
            cs_d_r <= cs_n_s;
            sck_d_r <= sck_s;
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rx_sh_r <= qspf_pkg::RST_DATA;
            bits_r <= 4'h0;
            O_RX_BYTE <= qspf_pkg::RST_DATA;
            O_RX_VALID <= 1'b0;
        end else begin
            O_RX_VALID <= 1'b0;
            if (cs_fall || !sel) begin
                bits_r <= 4'h0;
            end else if (samp) begin
                rx_sh_r <= rx_in;
                bits_r <= byte_done ? 4'h0 : bits_n;
                if (byte_done) begin
                    O_RX_BYTE <= rx_in;
                    O_RX_VALID <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            tx_sh_r <= qspf_pkg::RST_DATA;
            drv_r <= '0;
            O_TX_TAKE <= 1'b0;
        end else begin
            O_TX_TAKE <= tx_load && launch;
            if (!sel || rst_any) begin
                drv_r <= '0;
            end else if (launch) begin
                drv_r <= '{out: tx_val, oe: tx_oe};
                tx_sh_r <= tx_next;
            end
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_LANE <= 4'h0;
            O_LANE_OE <= 4'h0;
            O_START <= 1'b0;
            O_END <= 1'b0;
            O_ACTIVE <= 1'b0;
            O_STANDBY <= 1'b1;
            O_WP_N <= 1'b1;
            O_RESET_REQ <= 1'b0;
        end else begin
            O_LANE <= drv_r.out;
            O_LANE_OE <= (sel && !rst_any) ? drv_r.oe : 4'h0;
            O_START <= cs_fall && !rst_any;
            O_END <= cs_rise;
            O_ACTIVE <= state_nxt != qspf_pkg::ST_STANDBY;
            O_STANDBY <= state_nxt == qspf_pkg::ST_STANDBY;
            O_WP_N <= quad ? 1'b1 : lane_s[2];
            O_RESET_REQ <= rst_any;
        end
    end

    a_oe_off_deselect: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        cs_n_s |=> O_LANE_OE == 4'h0) else $error("lanes driven while deselected");
    a_oe_off_reset: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        !hw_rst_s |=> O_LANE_OE == 4'h0) else $error("lanes driven in reset");
    a_lane0_quiet: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        I_CFG.width == qspf_pkg::WIDTH_X1 && $stable(I_CFG) |=> !O_LANE_OE[0])
        else $error("lane zero driven in single mode");
    a_start_pulse: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        cs_fall && hw_rst_s && !l3_rst |=> O_START ##1 !O_START) else $error("start missed");
    a_end_pulse: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        cs_rise |=> O_END) else $error("end missed");
    a_busy_holds: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        state_r == qspf_pkg::ST_ACTIVE && cs_rise && I_EMBEDDED_BUSY && !rst_any |=> O_ACTIVE)
        else $error("standby during embedded op");
    a_active_sel: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        state_r == qspf_pkg::ST_ACTIVE && sel && !rst_any |=> O_ACTIVE && !O_STANDBY)
        else $error("not active while selected");
    a_reset_ds: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        cs_n_s && !hw_rst_s |=> O_RESET_REQ && O_STANDBY) else $error("reset ignored");
    a_sample_edge: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        !I_CFG.ddr && sck_fall |=> $stable(rx_sh_r)) else $error("sdr sample on fall");
    a_sdr_launch: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        sel && !rst_any && !I_CFG.ddr && sck_rise |=> $stable(drv_r))
        else $error("sdr launch on rise");
    // DDR keeps the falling edge as a sample point too
    a_ddr_fall: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        I_CFG.ddr && samp && sck_fall && !cs_fall |=> rx_sh_r == $past(rx_in))
        else $error("ddr fall sample lost");
    a_lane3_rst: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        I_CFG.reset_on_lane3 && cs_n_s && !lane_s[3] |=> O_RESET_REQ && O_STANDBY)
        else $error("lane three reset ignored");
    a_rst_standby: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        rst_any |=> O_STANDBY && !O_ACTIVE && !O_START) else $error("reset did not reinit");

    c_frame: cover property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) O_START ##[1:500] O_END);
    c_byte: cover property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) O_RX_VALID);
    c_busy: cover property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) state_r == qspf_pkg::ST_BUSY);
    c_ddr_byte: cover property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        I_CFG.ddr && O_RX_VALID);
    c_lane3_rst: cover property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        l3_rst);
endmodule
`default_nettype wire

// ---- verilog/qspf_pkg.sv ----
`default_nettype none
package qspf_pkg;
    localparam int LANES = 4;
    localparam logic [1:0] WIDTH_X1 = 2'h0;
    localparam logic [1:0] WIDTH_X2 = 2'h1;
    localparam logic [1:0] WIDTH_X4 = 2'h2;
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam int SHIFT_BITS = 8;

    typedef enum logic [2:0] {
        ST_STANDBY = 3'h1,
        ST_ACTIVE = 3'h2,
        ST_BUSY = 3'h4
    } qspf_state_e;

    typedef struct packed {
        logic [1:0] width;
        logic ddr;
        logic reset_on_lane3;
    } qspf_cfg_s;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } qspf_lanes_s;
endpackage
`default_nettype wire

// ---- verilog/qspf_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module qspf_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= '1;
            o_q <= '1;
        end else begin
            meta_r <= i_d;
            o_q <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ---- verif/qspf_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module qspf_host_model (
    input wire logic i_clk,
    input wire logic [3:0] i_dev_out,
    input wire logic [3:0] i_dev_oe,
    output logic o_cs_n,
    output logic o_sck,
    output wire logic [3:0] o_lane
);
    logic [3:0] drv = 4'h0;
    logic [3:0] hoe = 4'h0;
    logic wp = 1'b1;
    logic l3 = 1'b1;
    logic tog = 1'b0;
    // Released low lanes toggle so a stale value never passes
    wire logic [3:0] idle_w = {l3, wp, tog, ~tog};
    assign o_lane = (hoe & drv) | (~hoe & i_dev_oe & i_dev_out) | (~hoe & ~i_dev_oe & idle_w);
    always @(posedge i_clk) tog <= ~tog;
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
    end
    task automatic half();
        repeat (4) @(negedge i_clk);
    endtask
    task automatic sel(input logic v);
        o_cs_n = v;
        half();
    endtask
    // Clock idles low in both rates
    task automatic send(input logic [7:0] b, input int w, input bit ddr);
        for (int k = 8; k > 0; k -= w) begin
            drv = 4'((b >> (k - w)) & ((1 << w) - 1));
            hoe = 4'((1 << w) - 1);
            if (ddr) begin
                // Data moves midway between edges, so each edge sees it settled
                repeat (2) @(negedge i_clk);
                o_sck = ~o_sck;
                repeat (2) @(negedge i_clk);
            end else begin
                half();
                o_sck = 1'b1;
                half();
                o_sck = 1'b0;
            end
        end
        half();
        hoe = 4'h0;
    endtask
endmodule
`default_nettype wire

// ---- verif/qspf_pins_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        n_compared++; \
        if ((g) !== (e)) begin \
            mismatches++; \
            $display("mismatch %s exp %0h got %0h", nm, e, g); \
        end \
    end
module qspf_pins_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hw_n = 1'b1;
    logic hw_p = 1'b0;
    logic busy = 1'b0;
    logic [7:0] tx = 8'h00;
    qspf_pkg::qspf_cfg_s cfg = '0;
    wire logic cs_n, sck;
    wire logic [3:0] lane;
    logic [3:0] o_lane, oe;
    logic start, fin, act, stby, wp_n, rreq, rxv, take;
    logic [7:0] rxb;
    int mismatches = 0;
    int n_compared = 0;
    int n_st = 0, n_en = 0, cyc = 0;
    int n_tk = 0;
    logic take_d = 1'b0;
    logic [7:0] tx_k = 8'h00;
    logic [7:0] exp_b;
    logic [7:0] exp_q[$];
    // Lane image of a freshly loaded byte: MSB first, lane one alone in x1
    function automatic logic [3:0] exp_lanes(input logic [7:0] v, input logic [1:0] wd);
        if (wd == qspf_pkg::WIDTH_X4) return v[7:4];
        if (wd == qspf_pkg::WIDTH_X2) return {2'h0, v[7:6]};
        return {2'h0, v[7], 1'h0};
    endfunction
    initial begin
        forever #20 clk = ~clk;
    end
    qspf_host_model p (.i_clk(clk), .i_dev_out(o_lane), .i_dev_oe(oe), .o_cs_n(cs_n),
        .o_sck(sck), .o_lane(lane));
    qspf_pins dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_CS_N(cs_n), .I_SCK(sck),
        .I_LANE(lane), .I_HW_RESET_N(hw_n), .I_HW_RESET_PRESENT(hw_p), .I_CFG(cfg),
        .I_EMBEDDED_BUSY(busy), .I_TX_BYTE(tx), .O_LANE(o_lane), .O_LANE_OE(oe),
        .O_START(start), .O_END(fin), .O_ACTIVE(act), .O_STANDBY(stby), .O_WP_N(wp_n),
        .O_RESET_REQ(rreq), .O_RX_BYTE(rxb), .O_RX_VALID(rxv), .O_TX_TAKE(take));
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(negedge clk) begin
        cyc <= cyc + 1;
        take_d <= take;
        if (take) begin
            n_tk++;
            tx_k <= tx;
        end
        if (start) n_st++;
        if (fin) n_en++;
        if (take_d) `CHK("lane_out", exp_lanes(tx_k, cfg.width), o_lane & oe);
        if (rxv && exp_q.size() == 0) begin
            `CHK("rx_unexpected", 1'b0, rxv);
        end else if (rxv) begin
            exp_b = exp_q.pop_front();
            `CHK("rx_byte", exp_b, rxb);
        end
        if (cyc == 20000) begin
            mismatches++;
            test_done();
        end
    end
    task automatic frame(input int w, input bit ddr, input int nb);
        logic [7:0] b;
        int t0;
        t0 = n_tk;
        p.sel(1'b0);
        `CHK("active", 1'b1, act);
        repeat (nb) begin
            b = 8'($urandom);
            tx = 8'($urandom);
            exp_q.push_back(b);
            p.send(b, w, ddr);
            if (w == 1) `CHK("oe_x1", 4'h2, oe);
        end
        `CHK("tx_take", t0 + nb, n_tk);
        p.sel(1'b1);
        repeat (8) @(negedge clk);
    endtask
    task automatic look(input string nm, input logic e, input logic g);
        `CHK(nm, e, g);
    endtask
    initial begin
        int s0, e0;
        void'($urandom(32'h761432ad));
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        for (int m = 0; m < 6; m++) begin
            cfg.width = 2'(m / 2);
            cfg.ddr = m[0];
            s0 = n_st;
            e0 = n_en;
            frame(1 << (m / 2), m[0], 2);
            `CHK("start", s0 + 1, n_st);
            `CHK("end", e0 + 1, n_en);
            `CHK("oe_idle", 4'h0, oe);
            `CHK("standby", 1'b1, stby);
            `CHK("rx_left", 0, exp_q.size());
            $display("test mode %0d done", m);
        end
        cfg = '0;
        s0 = n_st;
        p.send(8'($urandom), 1, 1'b0);
        `CHK("desel_start", s0, n_st);
        busy = 1'b1;
        frame(1, 1'b0, 1);
        look("busy_active", 1'b1, act);
        busy = 1'b0;
        repeat (8) @(negedge clk);
        look("standby_after", 1'b1, stby);
        $display("test select done");
        hw_p = 1'b1;
        hw_n = 1'b0;
        repeat (8) @(negedge clk);
        look("rst_req", 1'b1, rreq);
        s0 = n_st;
        p.sel(1'b0);
        p.send(8'($urandom), 1, 1'b0);
        `CHK("oe_rst", 4'h0, oe);
        `CHK("start_rst", s0, n_st);
        p.sel(1'b1);
        hw_n = 1'b1;
        repeat (8) @(negedge clk);
        look("rst_rel", 1'b0, rreq);
        hw_p = 1'b0;
        hw_n = 1'b0;
        repeat (8) @(negedge clk);
        look("rst_absent", 1'b0, rreq);
        hw_n = 1'b1;
        cfg.reset_on_lane3 = 1'b1;
        p.l3 = 1'b0;
        repeat (8) @(negedge clk);
        look("lane3_rst", 1'b1, rreq);
        p.l3 = 1'b1;
        p.wp = 1'b0;
        repeat (8) @(negedge clk);
        look("wp_x1", 1'b0, wp_n);
        cfg.width = qspf_pkg::WIDTH_X4;
        repeat (8) @(negedge clk);
        look("wp_x4", 1'b1, wp_n);
        $display("test pins done");
        test_done();
    end
endmodule
`default_nettype wire
